// ### core/cbs_pkg.sv
package cbs_pkg;
    localparam logic [15:0] CBS_RESET_ADDR = 16'h0000;
    localparam logic [15:0] CBS_NMI_ADDR = 16'h0066;
    localparam logic [1:0] CBS_IM0 = 2'h0;
    localparam logic [1:0] CBS_RESET_START = 2'h2;
    localparam int CBS_REFRESH_BITS = 7;
    localparam int CBS_IO_AUTO_WAITS = 1;
    localparam int CBS_ACK_AUTO_WAITS = 2;

    typedef enum logic [1:0] {
        CBS_CYC_FETCH = 2'b00,
        CBS_CYC_MEM = 2'b01,
        CBS_CYC_IO = 2'b10,
        CBS_CYC_ACK = 2'b11
    } cbs_cyc_e;

    typedef enum logic [2:0] {
        CBS_ST_START = 3'b000,
        CBS_ST_T1 = 3'b001,
        CBS_ST_T2 = 3'b010,
        CBS_ST_TW = 3'b011,
        CBS_ST_T3 = 3'b100,
        CBS_ST_T4 = 3'b101,
        CBS_ST_HOLD = 3'b110
    } cbs_state_e;
endpackage

// ### core/cbs_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - memory_request_n low only while address holds a valid memory address.
// - non-maskable request beats maskable, ignores enable flag, restarts at 0066h.
// - read_strobe_n low when data wanted; target drives data with it.
// - reset clears enable flag, counter, vector page, refresh counter; mode 0.
// - during reset buses float and controls inactive.
// - two T cycles after reset release, then first fetch at 0000.
// - refresh strobe in fetch T3/T4, memory request with it in T3 only, refresh row on low bits.
// - wait states inserted while wait input sampled active.
// - write_strobe_n only while written data is stable.
// - machine cycles are three or more T states, lengthened by waits.
// - fetch puts program counter on address, then request and read strobe.
// - other memory cycles use request and read strobe as fetch does.
// - I/O cycles get exactly one automatic wait state.
// - maskable request sampled at final T state of each instruction.
// - acknowledge fetch uses io_request_n; interrupter supplies 8-bit vector.
// - acknowledge cycle has two automatic wait states.
// - non-maskable response is a read with data ignored, then restart.
// - hold request sampled at last T of cycle; float at next edge.
// - after halt, no-operation fetches with stopped indicator until interrupt.
// - bus_hold_grant_n low tells requester the bus is floating.
// - first_cycle_marker_n marks fetch with memory, acknowledge with io request.
// - maskable request honoured only when enable flag set.
module cbs_sequencer
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic reset_n,
    input wire logic wait_n,
    input wire logic maskable_irq_n,
    input wire logic nonmaskable_irq_n,
    input wire logic bus_hold_request_n,
    input wire logic [7:0] data_in,
    input wire logic cyc_req,
    input wire logic [1:0] cyc_kind,
    input wire logic cyc_write,
    input wire logic [15:0] cyc_addr,
    input wire logic [7:0] cyc_wdata,
    input wire logic cyc_last,
    input wire logic halt_cmd,
    input wire logic irq_enable_set,
    input wire logic irq_enable_clr,
    input wire logic [7:0] vector_page_wdata,
    input wire logic vector_page_we,
    output logic cyc_done,
    output logic [7:0] read_data,
    output logic [15:0] addr_out,
    output logic addr_oe_n,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic memory_request_n,
    output logic io_request_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic ctrl_oe_n,
    output logic first_cycle_marker_n,
    output logic refresh_strobe_n,
    output logic stopped_indicator_n,
    output logic bus_hold_grant_n,
    output logic irq_enable_flag,
    output logic [1:0] irq_mode,
    output logic [15:0] program_counter,
    output logic [7:0] vector_page_register,
    output logic [7:0] refresh_counter_register,
    output logic nmi_taken,
    output logic irq_taken
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
logic [1:0] rst_s_q, wait_s_q, int_s_q, nmi_s_q, hold_s_q;
always_ff @(posedge clk) begin
    rst_s_q <= {rst_s_q[0], reset_n};
    wait_s_q <= {wait_s_q[0], wait_n};
    int_s_q <= {int_s_q[0], maskable_irq_n};
    nmi_s_q <= {nmi_s_q[0], nonmaskable_irq_n};
    hold_s_q <= {hold_s_q[0], bus_hold_request_n};
end
wire in_reset = srst || !rst_s_q[1];
wire wait_act = !wait_s_q[1];
wire int_act = !int_s_q[1];
wire nmi_act = !nmi_s_q[1];
wire hold_act = !hold_s_q[1];

////////////////////////////////////////////////////////////////////////////////
// sequencer state
cbs_state_e state_q, state_d;
cbs_cyc_e kind_q;
logic write_q, last_q, halted_q, nmi_pend_q, nmi_resp_q, nmi_prev_q;
logic [1:0] start_q, autow_q;
logic [15:0] addr_q;
logic [7:0] wdata_q;
logic phase_q;

wire is_fetch = (kind_q == CBS_CYC_FETCH);
wire is_ack = (kind_q == CBS_CYC_ACK);
wire is_io = (kind_q == CBS_CYC_IO);
wire end_of_cycle = (state_q == CBS_ST_T4) || (state_q == CBS_ST_T3 && !is_fetch && !is_ack);
wire instr_end = end_of_cycle && (last_q || halted_q);
// sample at last T of the instruction; nmi first, int gated by flag
// edge, not level: a held request must not restart the service routine again
wire nmi_edge = nmi_act && !nmi_prev_q;
wire take_nmi = instr_end && (nmi_edge || nmi_pend_q);
wire take_int = instr_end && !take_nmi && int_act && irq_enable_flag;
wire go_hold = end_of_cycle && hold_act;
// refresh uses T3/T4 of a fetch; no auto-wait in fetch
wire wait_sample = (state_q == CBS_ST_T2) || (state_q == CBS_ST_TW);
wire extend = wait_sample && (autow_q != 2'h0 || wait_act);
wire [1:0] autow_init = is_io ? 2'(CBS_IO_AUTO_WAITS) : (is_ack ? 2'(CBS_ACK_AUTO_WAITS) : 2'h0);

always_comb begin
    state_d = state_q;
    case (state_q)
        CBS_ST_START: if (start_q == 2'h1) state_d = hold_act ? CBS_ST_HOLD : CBS_ST_T1;
        CBS_ST_T1: state_d = CBS_ST_T2;
        CBS_ST_T2: state_d = extend ? CBS_ST_TW : CBS_ST_T3;
        CBS_ST_TW: state_d = extend ? CBS_ST_TW : CBS_ST_T3;
        CBS_ST_T3: if (is_fetch || is_ack) state_d = CBS_ST_T4;
            else state_d = go_hold ? CBS_ST_HOLD : CBS_ST_T1;
        CBS_ST_T4: state_d = go_hold ? CBS_ST_HOLD : CBS_ST_T1;
        CBS_ST_HOLD: state_d = hold_act ? CBS_ST_HOLD : CBS_ST_T1;
        default: state_d = CBS_ST_START;
    endcase
end

// next cycle chosen at cycle end: nmi, int ack, halt fetch or caller's request
// two start states exactly: leave when the count reaches one
wire begin_next = (state_q == CBS_ST_START && start_q == 2'h1) || end_of_cycle;
always_ff @(posedge clk) begin
    if (in_reset) begin
        state_q <= CBS_ST_START;
        start_q <= CBS_RESET_START;
        kind_q <= CBS_CYC_FETCH;
        write_q <= 1'b0;
        last_q <= 1'b0;
        halted_q <= 1'b0;
        nmi_pend_q <= 1'b0;
        nmi_resp_q <= 1'b0;
        nmi_prev_q <= 1'b0;
        autow_q <= 2'h0;
        addr_q <= CBS_RESET_ADDR;
        wdata_q <= 8'h00;
        program_counter <= CBS_RESET_ADDR;
        irq_enable_flag <= 1'b0;
        irq_mode <= CBS_IM0;
        vector_page_register <= 8'h00;
        refresh_counter_register <= 8'h00;
        nmi_taken <= 1'b0;
        irq_taken <= 1'b0;
    end else begin
        state_q <= state_d;
        nmi_taken <= 1'b0;
        irq_taken <= 1'b0;
        if (start_q != 2'h0) start_q <= start_q - 2'h1;
        nmi_prev_q <= nmi_act;
        if (nmi_edge && !instr_end) nmi_pend_q <= 1'b1;
        if (vector_page_we) vector_page_register <= vector_page_wdata;
        if (irq_enable_set) irq_enable_flag <= 1'b1;
        else if (irq_enable_clr) irq_enable_flag <= 1'b0;
        if (state_q == CBS_ST_T1) autow_q <= autow_init;
        else if (extend && autow_q != 2'h0) autow_q <= autow_q - 2'h1;
        if (state_q == CBS_ST_T4 && is_fetch)
            refresh_counter_register[CBS_REFRESH_BITS-1:0] <=
                refresh_counter_register[CBS_REFRESH_BITS-1:0] + 7'h1;
        if (begin_next) begin
            nmi_resp_q <= 1'b0;
            if (take_nmi) begin
                nmi_pend_q <= 1'b0;
                irq_enable_flag <= 1'b0;
                halted_q <= 1'b0;
                nmi_taken <= 1'b1;
                nmi_resp_q <= 1'b1;
                kind_q <= CBS_CYC_FETCH;
                write_q <= 1'b0;
                last_q <= 1'b1;
                addr_q <= program_counter;
                program_counter <= CBS_NMI_ADDR;
            end else if (take_int) begin
                irq_enable_flag <= 1'b0;
                halted_q <= 1'b0;
                irq_taken <= 1'b1;
                kind_q <= CBS_CYC_ACK;
                write_q <= 1'b0;
                last_q <= 1'b1;
                addr_q <= program_counter;
            end else if (halted_q || (halt_cmd && instr_end)) begin
                halted_q <= 1'b1;
                kind_q <= CBS_CYC_FETCH;
                write_q <= 1'b0;
                last_q <= 1'b1;
                addr_q <= program_counter;
            end else if (cyc_req) begin
                kind_q <= cbs_cyc_e'(cyc_kind);
                write_q <= cyc_write && (cyc_kind == CBS_CYC_MEM || cyc_kind == CBS_CYC_IO);
                last_q <= cyc_last;
                if (cyc_kind == CBS_CYC_FETCH) begin
                    addr_q <= program_counter;
                    program_counter <= program_counter + 16'h0001;
                end else begin
                    addr_q <= cyc_addr;
                end
                wdata_q <= cyc_wdata;
            end else begin
                kind_q <= CBS_CYC_FETCH;
                write_q <= 1'b0;
                last_q <= 1'b1;
                addr_q <= program_counter;
                program_counter <= program_counter + 16'h0001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// strobes; phase_q is high only in the T state after T1, registered from the T1 decode
always_ff @(posedge clk) begin
    if (in_reset) phase_q <= 1'b0;
    else phase_q <= (state_q == CBS_ST_T1);
end

wire on_bus = (state_q != CBS_ST_START) && (state_q != CBS_ST_HOLD) && !in_reset;
wire in_t2_t3 = (state_q == CBS_ST_T2) || (state_q == CBS_ST_TW) || (state_q == CBS_ST_T3);
wire refresh_t = is_fetch && (state_q == CBS_ST_T4 || (state_q == CBS_ST_T3 && phase_q == 1'b0)) && on_bus;
wire req_phase = on_bus && (in_t2_t3 || (state_q == CBS_ST_T1 && phase_q));
wire mem_rd = req_phase && !is_io && !is_ack && !write_q && !(is_fetch && state_q == CBS_ST_T3 && !phase_q);
wire mem_cycle = req_phase && !is_io && !is_ack;

always_comb begin
    memory_request_n = 1'b1;
    io_request_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    refresh_strobe_n = 1'b1;
    first_cycle_marker_n = 1'b1;
    if (refresh_t) begin
        memory_request_n = (state_q == CBS_ST_T4);
        refresh_strobe_n = 1'b0;
    end else if (mem_cycle) begin
        memory_request_n = 1'b0;
        read_strobe_n = write_q;
        write_strobe_n = !(write_q && state_q != CBS_ST_T1);
    end
    if (on_bus && (is_io || is_ack) && in_t2_t3) begin
        io_request_n = 1'b0;
        read_strobe_n = !(is_io && !write_q);
        write_strobe_n = !(is_io && write_q && state_q != CBS_ST_T2);
    end
    if (on_bus && (is_fetch || is_ack) && !refresh_t && (state_q != CBS_ST_T4))
        first_cycle_marker_n = 1'b0;
    if (mem_rd && is_fetch) read_strobe_n = 1'b0;
end

wire [15:0] refresh_addr = {vector_page_register, 1'b0, refresh_counter_register[CBS_REFRESH_BITS-1:0]};
// registered bus: choose from the next state so the row stands in T3 and T4;
// T1 may still show the old address, harmless as no request is low then
wire refresh_next = is_fetch && (state_d == CBS_ST_T3 || state_d == CBS_ST_T4) && !in_reset;
always_ff @(posedge clk) begin
    addr_out <= refresh_next ? refresh_addr : addr_q;
    data_out <= wdata_q;
end

// float on reset and during hold; grant when floating for a requester
assign addr_oe_n = !on_bus;
assign ctrl_oe_n = !on_bus;
assign data_oe_n = !(on_bus && write_q && state_q != CBS_ST_T1);
assign bus_hold_grant_n = !(state_q == CBS_ST_HOLD && !in_reset);
assign stopped_indicator_n = !halted_q;

// data sampled at T3; nmi response data is discarded
always_ff @(posedge clk) begin
    if (in_reset) begin
        read_data <= 8'h00;
        cyc_done <= 1'b0;
    end else begin
        cyc_done <= end_of_cycle && !nmi_resp_q;
        if (state_q == CBS_ST_T3 && !write_q && !nmi_resp_q) read_data <= data_in;
    end
end

////////////////////////////////////////////////////////////////////////////////
AST_IO_ONE_WAIT: assert property (@(posedge clk) disable iff (in_reset)
    (state_q == CBS_ST_T1 && is_io) |=> ##1 (state_q == CBS_ST_TW))
    else $error("io cycle lacks its wait state");
AST_ACK_TWO_WAITS: assert property (@(posedge clk) disable iff (in_reset)
    (state_q == CBS_ST_T1 && is_ack) |=> ##1 (state_q == CBS_ST_TW) [*2])
    else $error("acknowledge cycle lacks two waits");
AST_MIN_THREE_T: assert property (@(posedge clk) disable iff (in_reset)
    (state_q == CBS_ST_T1) |=> (state_q != CBS_ST_T1) ##1 (state_q != CBS_ST_T1))
    else $error("machine cycle shorter than three states");
AST_NMI_VECTOR: assert property (@(posedge clk) disable iff (in_reset)
    take_nmi && begin_next |=> program_counter == CBS_NMI_ADDR)
    else $error("nmi did not restart at service address");
AST_INT_MASKED: assert property (@(posedge clk) disable iff (in_reset)
    irq_taken |-> $past(irq_enable_flag))
    else $error("maskable request taken while disabled");
AST_GRANT_FLOAT: assert property (@(posedge clk) disable iff (in_reset)
    !bus_hold_grant_n |-> addr_oe_n && ctrl_oe_n && data_oe_n)
    else $error("grant given while driving bus");
AST_IOREQ_EXCL: assert property (@(posedge clk) disable iff (in_reset)
    !io_request_n |-> memory_request_n)
    else $error("memory and io request together");
AST_HALT_SHOW: assert property (@(posedge clk) disable iff (in_reset)
    halted_q && !take_nmi && !take_int |=> !stopped_indicator_n)
    else $error("stopped indicator dropped without interrupt");
AST_WR_DATA: assert property (@(posedge clk) disable iff (in_reset)
    !write_strobe_n |-> !data_oe_n)
    else $error("write strobe without driven data");
AST_REFRESH_STROBE_N_MEMORY_REQUEST_N: assert property (@(posedge clk) disable iff (in_reset)
    (!refresh_strobe_n && state_q == CBS_ST_T3) |-> !memory_request_n)
    else $error("refresh strobe without memory request");
AST_REFRESH_STROBE_N_ROW: assert property (@(posedge clk) disable iff (in_reset)
    !refresh_strobe_n |-> addr_out[CBS_REFRESH_BITS-1:0] == refresh_counter_register[CBS_REFRESH_BITS-1:0])
    else $error("refresh row not on address bus");
AST_RESET_FLOAT: assert property (@(posedge clk)
    in_reset |-> addr_oe_n && data_oe_n && ctrl_oe_n && bus_hold_grant_n)
    else $error("bus driven during reset");
AST_START_TWO: assert property (@(posedge clk) disable iff (in_reset)
    $fell(in_reset) |-> (state_q == CBS_ST_START) ##1 (state_q == CBS_ST_START) ##1 (state_q != CBS_ST_START))
    else $error("start phase not two states");
AST_ACK_KIND: assert property (@(posedge clk) disable iff (in_reset)
    irq_taken |-> kind_q == CBS_CYC_ACK)
    else $error("accepted interrupt without acknowledge cycle");
AST_MEMORY_REQUEST_N_VALID: assert property (@(posedge clk) disable iff (in_reset)
    (!memory_request_n && refresh_strobe_n) |-> addr_out == addr_q)
    else $error("memory request without cycle address");
AST_HOLD_ENTRY: assert property (@(posedge clk) disable iff (in_reset)
    go_hold |=> !bus_hold_grant_n)
    else $error("hold request not granted at next edge");
AST_WR_NO_RD: assert property (@(posedge clk) disable iff (in_reset)
    !write_strobe_n |-> read_strobe_n)
    else $error("read and write strobes together");
AST_REFRESH_STROBE_N_COUNT: assert property (@(posedge clk) disable iff (in_reset)
    (state_q == CBS_ST_T4 && is_fetch) |=> refresh_counter_register[CBS_REFRESH_BITS-1:0] ==
        $past(refresh_counter_register[CBS_REFRESH_BITS-1:0]) + 7'h1)
    else $error("refresh row did not advance");
endmodule

// ### dv/cbs_bus_model.sv
`timescale 1ns/1ps
module cbs_bus_model (
    input wire logic clk,
    input wire logic [15:0] addr_out,
    input wire logic [7:0] data_out,
    input wire logic memory_request_n,
    input wire logic io_request_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic first_cycle_marker_n,
    input wire logic [7:0] vector,
    input wire logic [1:0] wait_len,
    output logic [7:0] data_in,
    output logic wait_n,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data
);
    logic [7:0] last_q = 8'h00;
    logic [1:0] wcnt_q = 2'h0;
    logic acc_q = 1'h0;
    wire logic ack = !io_request_n && !first_cycle_marker_n;
    wire logic rd = !read_strobe_n && (!memory_request_n || !io_request_n);
    wire logic acc = rd || !write_strobe_n;
    // undriven bus toggles so a stale value can never pass for a read
    assign data_in = ack ? vector : rd ? (addr_out[7:0] ^ (memory_request_n ? 8'hA5 : 8'h5A)) : ~last_q;
    assign wait_n = (wcnt_q == 2'h0);
    always @(posedge clk) begin
        last_q <= data_in;
        acc_q <= acc;
        if (acc && !acc_q) begin
            wcnt_q <= wait_len;
        end else if (wcnt_q != 2'h0) begin
            wcnt_q <= wcnt_q - 2'h1;
        end
        if (!write_strobe_n) begin
            wr_addr <= addr_out;
            wr_data <= data_out;
        end
    end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    import cbs_pkg::*;
    logic clk = 1'h0, srst = 1'h1, reset_n = 1'h1, maskable_irq_n = 1'h1, nonmaskable_irq_n = 1'h1;
    logic bus_hold_request_n = 1'h1, cyc_req = 1'h1, cyc_write = 1'h0, cyc_last = 1'h1, halt_cmd = 1'h0;
    logic irq_enable_set = 1'h0, irq_enable_clr = 1'h0, vector_page_we = 1'h0;
    logic [1:0] cyc_kind = CBS_CYC_FETCH, wait_len = 2'h0, irq_mode;
    logic [15:0] cyc_addr = 16'h0000, addr_out, program_counter, wr_addr;
    logic [7:0] cyc_wdata = 8'h00, vector_page_wdata = 8'h00, data_in, read_data, data_out, wr_data;
    logic [7:0] vector_page_register, refresh_counter_register;
    logic wait_n, cyc_done, addr_oe_n, data_oe_n, memory_request_n, io_request_n, read_strobe_n, write_strobe_n;
    logic ctrl_oe_n, first_cycle_marker_n, refresh_strobe_n, stopped_indicator_n, bus_hold_grant_n;
    logic irq_enable_flag, nmi_taken, irq_taken;
    int num_errors = 0, check_count = 0, tick = 0, prev_done = 0, span = 0, hits;
    cbs_sequencer u_cbs_sequencer (.clk, .srst, .reset_n, .wait_n, .maskable_irq_n, .nonmaskable_irq_n,
        .bus_hold_request_n, .data_in, .cyc_req, .cyc_kind, .cyc_write, .cyc_addr, .cyc_wdata, .cyc_last,
        .halt_cmd, .irq_enable_set, .irq_enable_clr, .vector_page_wdata, .vector_page_we, .cyc_done,
        .read_data, .addr_out, .addr_oe_n, .data_out, .data_oe_n, .memory_request_n, .io_request_n,
        .read_strobe_n, .write_strobe_n, .ctrl_oe_n, .first_cycle_marker_n, .refresh_strobe_n,
        .stopped_indicator_n, .bus_hold_grant_n, .irq_enable_flag, .irq_mode, .program_counter,
        .vector_page_register, .refresh_counter_register, .nmi_taken, .irq_taken);
    cbs_bus_model u_cbs_bus_model (.clk, .addr_out, .data_out, .memory_request_n, .io_request_n,
        .read_strobe_n, .write_strobe_n, .first_cycle_marker_n, .vector(8'hC7), .wait_len, .data_in,
        .wait_n, .wr_addr, .wr_data);
    initial begin
        forever #5 clk = ~clk;
    end
    // span = clocks between consecutive completions, i.e. length of the last cycle
    always @(posedge clk) begin
        tick <= tick + 1;
        if (cyc_done === 1'h1) begin
            span <= tick - prev_done;
            prev_done <= tick;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic bit cond(input int s);
        case (s)
            0: return !first_cycle_marker_n && !memory_request_n && !read_strobe_n;
            1: return !io_request_n && first_cycle_marker_n;
            2: return !memory_request_n && !read_strobe_n && first_cycle_marker_n;
            3: return !write_strobe_n;
            4: return cyc_done === 1'h1;
            5: return !refresh_strobe_n;
            6: return !io_request_n && !first_cycle_marker_n;
            7: return irq_taken === 1'h1;
            8: return nmi_taken === 1'h1;
            9: return !bus_hold_grant_n;
            10: return bus_hold_grant_n === 1'h1;
            11: return !stopped_indicator_n;
            12: return cond(0) && addr_out === CBS_NMI_ADDR;
            default: return stopped_indicator_n === 1'h1;
        endcase
    endfunction
    task automatic wait_for(input int s, input int bound);
        int n;
        n = 0;
        while (!cond(s) && n < bound) begin
            step(1);
            n++;
        end
        if (!cond(s)) begin
            num_errors++;
            $display("CHECK FAILED wait %0d expected 1 seen 0", s);
            tally_and_finish();
        end
    endtask
    task automatic watch(input int s, input int n);
        hits = 0;
        repeat (n) begin
            step(1);
            hits += cond(s);
        end
    endtask
    // skip the previous cycle's completion, then time this one
    task automatic cycle_end();
        step(2);
        wait_for(4, 20);
        step(1);
    endtask
    task automatic request(input logic [1:0] kind, input logic wr, input logic [15:0] a, input int s);
        cyc_kind = kind;
        cyc_write = wr;
        cyc_addr = a;
        cyc_wdata = 8'h9B;
        wait_for(s, 20);
        cyc_kind = CBS_CYC_FETCH;
        cyc_write = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic pin);
        if (pin) begin
            reset_n = 1'h0;
        end else begin
            srst = 1'h1;
        end
        step(8);
        check("oe", {addr_oe_n, data_oe_n, ctrl_oe_n}, 3'h7);
        check("ctrl", {memory_request_n, io_request_n, read_strobe_n, write_strobe_n, bus_hold_grant_n}, 5'h1F);
        check("regs", {program_counter, vector_page_register, refresh_counter_register}, 32'h0000_0000);
        check("ie", {irq_enable_flag, irq_mode}, {1'h0, CBS_IM0});
        srst = 1'h0;
        reset_n = 1'h1;
        wait_for(0, 10);
        check("first fetch", addr_out, CBS_RESET_ADDR);
    endtask
    task automatic refresh_test();
        logic [6:0] row;
        wait_for(0, 10);
        wait_for(5, 10);
        check("refresh_strobe_n memory_request_n", memory_request_n, 1'h0);
        row = addr_out[6:0];
        step(3);
        wait_for(5, 10);
        check("row", addr_out[6:0], row + 7'h01);
    endtask
    task automatic bus_cycles_test();
        request(CBS_CYC_IO, 1'h0, 16'h0042, 1);
        cycle_end();
        check("io len", span, 4);
        check("io data", read_data, 8'hE7);
        request(CBS_CYC_MEM, 1'h1, 16'h1234, 3);
        check("wr memory_request_n", memory_request_n, 1'h0);
        cycle_end();
        check("wr len", span, 3);
        check("wr", {wr_addr, wr_data}, 24'h1234_9B);
        wait_len = 2'h2;
        request(CBS_CYC_MEM, 1'h0, 16'h00F0, 2);
        check("rd addr", addr_out, 16'h00F0);
        cycle_end();
        wait_len = 2'h0;
        check("rd data", read_data, 8'hAA);
        check("rd waits", span > 3, 1'h1);
    endtask
    task automatic irq_test();
        irq_enable_clr = 1'h1;
        maskable_irq_n = 1'h0;
        watch(7, 30);
        check("masked", hits, 0);
        irq_enable_clr = 1'h0;
        irq_enable_set = 1'h1;
        step(1);
        irq_enable_set = 1'h0;
        wait_for(6, 40);
        maskable_irq_n = 1'h1;
        check("ack memory_request_n", memory_request_n, 1'h1);
        cycle_end();
        check("ack len", span, 6);
        check("ie after", irq_enable_flag, 1'h0);
    endtask
    task automatic halt_nmi_test();
        halt_cmd = 1'h1;
        wait_for(11, 20);
        halt_cmd = 1'h0;
        watch(13, 20);
        check("halted", hits, 0);
        nonmaskable_irq_n = 1'h0;
        wait_for(8, 40);
        nonmaskable_irq_n = 1'h1;
        wait_for(12, 40);
        check("resumed", stopped_indicator_n, 1'h1);
    endtask
    task automatic hold_test();
        bus_hold_request_n = 1'h0;
        wait_for(9, 20);
        check("float", {addr_oe_n, data_oe_n, ctrl_oe_n}, 3'h7);
        watch(10, 12);
        check("held", hits, 0);
        bus_hold_request_n = 1'h1;
        wait_for(10, 20);
        wait_for(0, 20);
    endtask
    initial begin
        do_reset(1'h0);
        refresh_test();
        bus_cycles_test();
        irq_test();
        halt_nmi_test();
        hold_test();
        vector_page_wdata = 8'h3C;
        vector_page_we = 1'h1;
        step(1);
        vector_page_we = 1'h0;
        step(1);
        check("page", vector_page_register, 8'h3C);
        do_reset(1'h1);
        tally_and_finish();
    end
endmodule
